/* File: hdl/angle_port_pkg.sv */
// Shared constants for the angle sensor serial port and its outputs.
// Assumes a 100 MHz system clock; all pins are sampled by that clock.
package angle_port_pkg;

    // ********************************
    // Clock and timing
    // ********************************
    localparam int CLK_HZ = 100_000_000;
    localparam int FE_RATE_HZ = 1_000_000;
    localparam int FE_DIV = CLK_HZ / FE_RATE_HZ;
    localparam int NVM_MS = 20;
    localparam int NVM_CYCLES = NVM_MS * (CLK_HZ / 1000);
    localparam int NVM_CNT_W = 22;
    localparam int FRAME_BITS = 16;

    // ********************************
    // Filter: tau = 0.38 / 90 Hz, gains as shifts at the sample rate
    // ********************************
    localparam int FRAC_W = 24;
    localparam int K1_SHIFT = 11;
    localparam int K2_SHIFT = 24;

    // ********************************
    // Commands and register map
    // ********************************
    localparam logic [2:0] CMD_READ = 3'h2;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [4:0] ADDR_ZERO_LO = 5'h00;
    localparam logic [4:0] ADDR_ZERO_HI = 5'h01;
    localparam logic [4:0] ADDR_PPT_LO = 5'h04;
    localparam logic [4:0] ADDR_PPT_HI = 5'h05;
    localparam logic [4:0] ADDR_THRESH = 5'h06;
    localparam logic [4:0] ADDR_DIR = 5'h09;
    localparam logic [4:0] ADDR_FLAGS = 5'h1b;
    localparam logic [7:0] RST_PPT_LO = 8'hc0;
    localparam logic [7:0] RST_PPT_HI = 8'h0f;
    localparam logic [7:0] RST_THRESH = 8'h1c;
    localparam int DIR_BIT = 7;
    localparam int LT_POS = 5;
    localparam int HT_POS = 2;

    typedef enum logic [0:0] {RESP_ANGLE = 1'b0, RESP_REG = 1'b1} resp_t;

endpackage

/* File: hdl/cfg_mem_if.sv */
// Carrier between the port logic and the configuration memory.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface cfg_mem_if;
    logic [4:0] raddr;
    logic [7:0] rdata;
    logic we;
    logic [4:0] waddr;
    logic [7:0] wdata;
    logic [15:0] zero;
    logic [5:0] ppt;
    logic [2:0] low_thr;
    logic [2:0] high_thr;
    logic dir;
    modport port (output raddr, we, waddr, wdata,
                  input rdata, zero, ppt, low_thr, high_thr, dir);
    modport mem (input raddr, we, waddr, wdata,
                 output rdata, zero, ppt, low_thr, high_thr, dir);
endinterface

/* File: hdl/cfg_mem.sv */
// Configuration memory: 32 bytes, registered read, decoded fields.
// Assumes a synchronised active-low reset from the top module.
`timescale 1ns/1ps
module cfg_mem
    import angle_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    cfg_mem_if.mem bus
);

    typedef struct packed {
        logic [31:0][7:0] mem;
        logic [7:0] rdata;
    } mem_state_t;

    mem_state_t st_reg, st_next;

    function automatic logic [31:0][7:0] reset_image();
        logic [31:0][7:0] img;
        img = '0;
        img[ADDR_PPT_LO] = RST_PPT_LO;
        img[ADDR_PPT_HI] = RST_PPT_HI;
        img[ADDR_THRESH] = RST_THRESH;
        return img;
    endfunction

    localparam logic [31:0][7:0] RESET_IMAGE = reset_image();

    always_comb
    begin
        st_next = st_reg;
        if (bus.we)
        begin
            st_next.mem[bus.waddr] = bus.wdata;
        end
        st_next.rdata = st_reg.mem[bus.raddr];
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_reg <= {RESET_IMAGE, 8'h00};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign bus.rdata = st_reg.rdata;
    assign bus.zero = {st_reg.mem[ADDR_ZERO_HI], st_reg.mem[ADDR_ZERO_LO]};
    assign bus.ppt = {st_reg.mem[ADDR_PPT_HI][3:0], st_reg.mem[ADDR_PPT_LO][7:6]};
    assign bus.low_thr = st_reg.mem[ADDR_THRESH][LT_POS +: 3];
    assign bus.high_thr = st_reg.mem[ADDR_THRESH][HT_POS +: 3];
    assign bus.dir = st_reg.mem[ADDR_DIR][DIR_BIT];

endmodule // cfg_mem

/* File: hdl/angle_sensor_spi_port.sv */
// Serial port, angle conditioning, incremental and field flag outputs.
// Assumes serial pins come from the host asynchronously; raw angle and
// field strength come from the front end on clk_i.
//
// Contract
// - Detect mode 0 or 3 automatically
// - Sample on rising, change on falling edge
// - MSB first, select idles high
// - Low flag when field below low threshold
// - High flag when field above high threshold
// - Each incremental output has inverted twin
// - Second order zero-latency tracking filter
// - Programmable rotation direction and zero angle
// - Angle read: 8 bits then zeros
// - Register read: command 010 plus address
// - Register write: command 100, echo next frame
`timescale 1ns/1ps
module angle_sensor_spi_port
    import angle_port_pkg::*;
#(
    parameter int NVM_WAIT = NVM_CYCLES
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic [15:0] raw_angle_i,
    input wire logic [7:0] field_strength_i,
    output logic chan_a_o,
    output logic chan_a_n_o,
    output logic chan_b_o,
    output logic chan_b_n_o,
    output logic index_z_o,
    output logic index_z_n_o,
    output logic field_low_flag_o,
    output logic field_high_flag_o
);

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        logic [2:0] sck_s;
        logic [2:0] cs_s;
        logic [2:0] mosi_s;
        logic sck_l;
        logic cs_l;
        logic mode3;
        logic skip;
        logic [4:0] bits;
        logic [15:0] rx;
        logic [15:0] tx;
        resp_t resp;
        logic [4:0] resp_addr;
        logic wpend;
        logic [4:0] waddr;
        logic [7:0] wdata;
        logic [NVM_CNT_W-1:0] wcnt;
        logic [6:0] fe_div;
        logic fe_tick;
        logic signed [39:0] y;
        logic signed [39:0] v;
        logic miso;
        logic miso_oe;
        logic a;
        logic a_n;
        logic b;
        logic b_n;
        logic z;
        logic z_n;
        logic lowf;
        logic highf;
    } port_state_t;

    port_state_t st_reg, st_next;
    logic [1:0] rst_sync_reg;
    logic rstn;
    cfg_mem_if cfg ();

    cfg_mem u_cfg_mem (
        .clk_i(clk_i),
        .rstn_i(rstn),
        .bus(cfg.mem)
    );

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_sync_reg <= 2'b00;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rstn = rst_sync_reg[1];

    function automatic logic settle(input logic [2:0] s, input logic lvl);
        return (s[1] == s[2]) ? s[2] : lvl;
    endfunction

    // ********************************
    // Next state
    // ********************************
    logic sck_n, cs_n, sck_rise, sck_fall, cs_fall, cs_rise;
    logic signed [15:0] err;
    logic [15:0] filt, oriented, aout;
    logic [24:0] prod;
    logic [7:0] pos, reg_val;
    logic [15:0] load;

    always_comb
    begin
        st_next = st_reg;
        st_next.sck_s = {st_reg.sck_s[1:0], sclk_i};
        st_next.cs_s = {st_reg.cs_s[1:0], cs_n_i};
        st_next.mosi_s = {st_reg.mosi_s[1:0], mosi_i};
        sck_n = settle(st_reg.sck_s, st_reg.sck_l);
        cs_n = settle(st_reg.cs_s, st_reg.cs_l);
        st_next.sck_l = sck_n;
        st_next.cs_l = cs_n;
        sck_rise = !st_reg.sck_l && sck_n;
        sck_fall = st_reg.sck_l && !sck_n;
        cs_fall = st_reg.cs_l && !cs_n;
        cs_rise = !st_reg.cs_l && cs_n;

        filt = st_reg.y[39:24];
        oriented = cfg.dir ? 16'(-filt) : filt;
        aout = 16'(oriented + cfg.zero);
        reg_val = (st_reg.resp_addr == ADDR_FLAGS) ?
            {st_reg.highf, st_reg.lowf, 6'h00} : cfg.rdata;
        load = (st_reg.resp == RESP_REG) ? {reg_val, 8'h00} : {aout[15:8], 8'h00};

        if (cs_fall)
        begin
            st_next.bits = 5'h00;
            st_next.mode3 = st_reg.sck_l;
            st_next.skip = st_reg.sck_l;
            st_next.tx = load;
            st_next.miso = load[15];
            st_next.miso_oe = 1'b1;
        end
        else if (!st_reg.cs_l && !cs_rise)
        begin
            if (sck_rise)
            begin
                st_next.rx = {st_reg.rx[14:0], st_reg.mosi_s[2]};
                if (st_reg.bits != 5'h1f)
                begin
                    st_next.bits = st_reg.bits + 5'h01;
                end
            end
            if (sck_fall)
            begin
                if (st_reg.skip)
                begin
                    st_next.skip = 1'b0;
                end
                else
                begin
                    st_next.tx = {st_reg.tx[14:0], 1'b0};
                    st_next.miso = st_reg.tx[14];
                end
            end
        end
        if (st_reg.wpend)
        begin
            if (st_reg.wcnt == '0)
            begin
                st_next.wpend = 1'b0;
            end
            else
            begin
                st_next.wcnt = st_reg.wcnt - NVM_CNT_W'(1);
            end
        end
        if (cs_rise)
        begin
            st_next.miso = 1'b0;
            st_next.miso_oe = 1'b0;
            st_next.resp = RESP_ANGLE;
            if (st_reg.bits == 5'(FRAME_BITS))
            begin
                if (st_reg.rx[15:13] == CMD_READ)
                begin
                    st_next.resp = RESP_REG;
                    st_next.resp_addr = st_reg.rx[12:8];
                end
                else if (st_reg.rx[15:13] == CMD_WRITE)
                begin
                    st_next.resp = RESP_REG;
                    st_next.resp_addr = st_reg.rx[12:8];
                    st_next.wpend = 1'b1;
                    st_next.waddr = st_reg.rx[12:8];
                    st_next.wdata = st_reg.rx[7:0];
                    st_next.wcnt = NVM_CNT_W'(NVM_WAIT - 1);
                end
            end
        end

        st_next.fe_tick = 1'b0;
        if (st_reg.fe_div == 7'(FE_DIV - 1))
        begin
            st_next.fe_div = 7'h00;
            st_next.fe_tick = 1'b1;
        end
        else
        begin
            st_next.fe_div = st_reg.fe_div + 7'h01;
        end
        err = signed'(16'(raw_angle_i - filt));
        if (st_reg.fe_tick)
        begin
            st_next.v = st_reg.v + (40'(err) <<< (FRAC_W - K2_SHIFT));
            st_next.y = st_reg.y + st_reg.v + (40'(err) <<< (FRAC_W - K1_SHIFT));
        end

        prod = 25'(aout * {1'b0, 7'(cfg.ppt) + 7'h01, 2'b00});
        pos = prod[23:16];
        st_next.a = pos[1];
        st_next.b = pos[1] ^ pos[0];
        st_next.z = (pos == 8'h00);
        st_next.a_n = !pos[1];
        st_next.b_n = !(pos[1] ^ pos[0]);
        st_next.z_n = (pos != 8'h00);
        st_next.lowf = field_strength_i < {cfg.low_thr, 5'h00};
        st_next.highf = field_strength_i > {cfg.high_thr, 5'h00};
    end

    always_ff @(posedge clk_i or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= '0;
            st_reg.sck_s <= 3'h0;
            st_reg.cs_s <= 3'h7;
            st_reg.cs_l <= 1'b1;
            st_reg.a_n <= 1'b1;
            st_reg.b_n <= 1'b1;
            st_reg.z_n <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign cfg.raddr = st_reg.resp_addr;
    assign cfg.we = st_reg.wpend && (st_reg.wcnt == '0);
    assign cfg.waddr = st_reg.waddr;
    assign cfg.wdata = st_reg.wdata;
    assign miso_o = st_reg.miso;
    assign miso_oe_o = st_reg.miso_oe;
    assign chan_a_o = st_reg.a;
    assign chan_a_n_o = st_reg.a_n;
    assign chan_b_o = st_reg.b;
    assign chan_b_n_o = st_reg.b_n;
    assign index_z_o = st_reg.z;
    assign index_z_n_o = st_reg.z_n;
    assign field_low_flag_o = st_reg.lowf;
    assign field_high_flag_o = st_reg.highf;

    // ********************************
    // Assertions
    // ********************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn);

    property p_mode_detect;
        cs_fall |=> st_reg.mode3 == $past(st_reg.sck_l) && st_reg.skip == st_reg.mode3;
    endproperty
    a_mode_detect: assert property (p_mode_detect) else $error("mode not latched");

    property p_rx_on_rise;
        !st_reg.cs_l && !cs_rise && sck_rise |=> st_reg.rx[0] == $past(st_reg.mosi_s[2]);
    endproperty
    a_rx_on_rise: assert property (p_rx_on_rise) else $error("bad sample");

    property p_msb_first;
        cs_fall |=> st_reg.miso == st_reg.tx[15] && st_reg.miso_oe;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("msb not first");

    property p_angle_tail;
        cs_fall && st_reg.resp == RESP_ANGLE |=> st_reg.tx[7:0] == 8'h00;
    endproperty
    a_angle_tail: assert property (p_angle_tail) else $error("tail not zero");

    property p_read_cmd;
        cs_rise && st_reg.bits == 5'h10 && st_reg.rx[15:13] == 3'h2
            |=> st_reg.resp == RESP_REG && st_reg.resp_addr == $past(st_reg.rx[12:8]);
    endproperty
    a_read_cmd: assert property (p_read_cmd) else $error("read not decoded");

    property p_write_cmd;
        cs_rise && st_reg.bits == 5'h10 && st_reg.rx[15:13] == 3'h4
            |=> st_reg.wpend && st_reg.wdata == $past(st_reg.rx[7:0]);
    endproperty
    a_write_cmd: assert property (p_write_cmd) else $error("write not taken");

    property p_release;
        cs_rise |=> !st_reg.miso_oe ##1 !st_reg.miso_oe;
    endproperty
    a_release: assert property (p_release) else $error("miso still driven");

    property p_fe_rate;
        st_reg.fe_tick |=> !st_reg.fe_tick [*8];
    endproperty
    a_fe_rate: assert property (p_fe_rate) else $error("sample rate wrong");

    property p_twins;
        st_reg.a_n != st_reg.a && st_reg.b_n != st_reg.b && st_reg.z_n != st_reg.z;
    endproperty
    a_twins: assert property (p_twins) else $error("twin not inverse");

    property p_low_flag;
        field_strength_i < {cfg.low_thr, 5'h00} |=> st_reg.lowf;
    endproperty
    a_low_flag: assert property (p_low_flag) else $error("low flag missing");

    property p_high_flag;
        field_strength_i > {cfg.high_thr, 5'h00} |=> st_reg.highf;
    endproperty
    a_high_flag: assert property (p_high_flag) else $error("high flag missing");

    c_mode3: cover property (cs_fall && st_reg.sck_l);
    c_write: cover property (cfg.we);
    c_read: cover property (cs_fall && st_reg.resp == RESP_REG);

endmodule // angle_sensor_spi_port

/* File: test/spi_host_model.sv */
// Behavioural serial host that drives frames into the angle port.
// Assumes the bench clock paces it; the data line has a pull-down.
`timescale 1ns/1ps
module spi_host_model
(
    input wire logic clk_i,
    input wire logic miso_i,
    input wire logic miso_oe_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o
);
    // ********************************
    // Timing
    // ********************************
    localparam int HALF = 8;
    localparam int GAP = 80;

    logic line;

    // Released data line falls to the pull-down level
    assign line = miso_oe_i ? miso_i : 1'b0;

    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // ********************************
    // One frame of nbits, mode3 picks the idle clock level
    // ********************************
    task automatic xfer(input logic mode3, input int nbits, input logic [15:0] tx,
                        output logic [15:0] rx);
        rx = 16'h0000;
        sclk_o <= mode3;
        wait_clk(HALF);
        cs_n_o <= 1'b0;
        mosi_o <= tx[15];
        for (int i = 0; i < nbits; i++)
        begin
            wait_clk(HALF);
            sclk_o <= 1'b0;
            mosi_o <= tx[15 - i];
            wait_clk(HALF);
            rx = {rx[14:0], line};
            sclk_o <= 1'b1;
        end
        wait_clk(HALF);
        sclk_o <= mode3;
        wait_clk(HALF);
        cs_n_o <= 1'b1;
        mosi_o <= 1'b0;
        wait_clk(GAP);
    endtask
endmodule // spi_host_model

/* File: test/tb_top.sv */
// Self-checking bench for the angle sensor serial port.
// Assumes the host model above and the design package.
`timescale 1ns/1ps
module tb_top;
    import angle_port_pkg::*;
    localparam int NVM_SIM = 50;
    localparam int LIMIT = 40000;
    localparam logic [4:0] RD_ADDR [4] = '{ADDR_PPT_LO, ADDR_PPT_HI, ADDR_THRESH, ADDR_DIR};
    localparam logic [7:0] RD_VAL [4] = '{8'hc0, 8'h0f, 8'h1c, 8'h00};
    localparam logic [7:0] FLD [4] = '{8'h3f, 8'h40, 8'ha0, 8'ha1};
    localparam logic [1:0] FLG [4] = '{2'h2, 2'h0, 2'h0, 2'h1};

    logic clk_i;
    logic resetn_i;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic [7:0] field;
    logic [15:0] raw_angle;
    logic a, a_n, b, b_n, z, z_n, f_lo, f_hi;
    logic [15:0] rx;
    int error_cnt;
    int checks_done;
    int cycles;

    angle_sensor_spi_port #(.NVM_WAIT(NVM_SIM)) uut (
        .clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
        .raw_angle_i(raw_angle), .field_strength_i(field),
        .chan_a_o(a), .chan_a_n_o(a_n), .chan_b_o(b), .chan_b_n_o(b_n),
        .index_z_o(z), .index_z_n_o(z_n),
        .field_low_flag_o(f_lo), .field_high_flag_o(f_hi));

    spi_host_model host (
        .clk_i(clk_i), .miso_i(miso), .miso_oe_i(miso_oe),
        .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

    // ********************************
    // Clock and timeout
    // ********************************
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial
    begin
        cycles = 0;
        forever
        begin
            @(posedge clk_i);
            cycles++;
            if (cycles == LIMIT)
            begin
                error_cnt++;
                conclude();
            end
        end
    end

    // ********************************
    // Shared tasks
    // ********************************
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic frame(input logic m, input logic [15:0] tx, input logic [15:0] exp);
        host.xfer(m, 16, tx, rx);
        check("miso frame", rx, exp);
    endtask

    task automatic wr(input logic m, input logic [4:0] addr, input logic [7:0] data);
        host.xfer(m, 16, {CMD_WRITE, addr, data}, rx);
        host.wait_clk(NVM_SIM);
        frame(m, 16'h0000, {data, 8'h00});
    endtask

    task automatic rd(input logic m, input logic [4:0] addr, input logic [7:0] exp);
        host.xfer(m, 16, {CMD_READ, addr, 8'h00}, rx);
        frame(m, 16'h0000, {exp, 8'h00});
    endtask

    task automatic abz(input logic [5:0] exp);
        check("abz pairs", {10'h000, a, a_n, b, b_n, z, z_n}, {10'h000, exp});
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial
    begin
        error_cnt = 0;
        checks_done = 0;
        resetn_i = 1'b0;
        field = 8'h80;
        raw_angle = 16'h0000;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        host.wait_clk(10);
        check("miso enable idle", {15'h0000, miso_oe}, 16'h0000);
        abz(6'b010110);
        foreach (RD_ADDR[i])
            rd(i[0], RD_ADDR[i], RD_VAL[i]);
        frame(1'b0, 16'h0000, 16'h0000);
        wr(1'b1, ADDR_ZERO_HI, 8'ha5);
        wr(1'b0, ADDR_DIR, 8'h80);
        frame(1'b1, 16'h0000, 16'ha500);
        abz(6'b011001);
        host.xfer(1'b0, 8, {CMD_READ, ADDR_DIR, 8'h00}, rx);
        frame(1'b1, 16'h0000, 16'ha500);
        wr(1'b0, ADDR_THRESH, 8'h54);
        foreach (FLD[i])
        begin
            @(posedge clk_i);
            field <= FLD[i];
            host.wait_clk(4);
            check("field flags", {14'h0000, f_lo, f_hi}, {14'h0000, FLG[i]});
        end
        rd(1'b1, ADDR_FLAGS, 8'h80);
        @(posedge clk_i);
        raw_angle <= 16'h4000;
        host.wait_clk(6400);
        host.xfer(1'b0, 16, 16'h0000, rx);
        check("angle tracks", {15'h0000, rx[15:8] < 8'ha5}, 16'h0001);
        conclude();
    end
endmodule // tb_top
